// [rtl/sdm_pkg.sv]
// Package for the SDRAM module command-pin front end.
// Assumes one system clock; all pins synchronous to it.
package sdm_pkg;
   localparam int DATA_W      = 64;
   localparam int LANES       = 8;
   localparam int LANE_W      = 8;
   localparam int BANK_W      = 2;
   localparam int ADDR_W      = 13;
   localparam int ROW_W_SMALL = 12;
   localparam int ROW_W_LARGE = 13;
   localparam int COL_W       = 9;
   localparam int AP_BIT      = 10;
   localparam int MASK_LAT    = 2;
   localparam int CL_LSB      = 4;
   localparam int BL_LSB      = 0;
   localparam int MODE_W      = 13;
   localparam logic [12:0] MODE_RST = 13'h0020;

   // Command code {select_n, row_n, col_n, write_n}
   localparam logic [3:0] CMD_NOP   = 4'h7;
   localparam logic [3:0] CMD_ACT   = 4'h3;
   localparam logic [3:0] CMD_RD    = 4'h5;
   localparam logic [3:0] CMD_WR    = 4'h4;
   localparam logic [3:0] CMD_PRE   = 4'h2;
   localparam logic [3:0] CMD_REF   = 4'h1;
   localparam logic [3:0] CMD_MODE  = 4'h0;
   localparam logic [3:0] CMD_BST   = 4'h6;

   typedef struct packed {
      logic        select_n;
      logic        row_n;
      logic        col_n;
      logic        write_n;
   } sdm_cmd_t;

   typedef struct packed {
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] addr;
   } sdm_addr_t;

   typedef enum logic [2:0] {
      ST_RUN     = 3'b001,
      ST_READ    = 3'b010,
      ST_SUSPEND = 3'b100
   } sdm_state_t;
endpackage : sdm_pkg

// [rtl/sdm_mem.sv]
// Byte-lane masked storage array, registered read.
// Assumes single clock, synchronous access.
`timescale 1ns/1ps
`default_nettype none
module sdm_mem #(
   parameter int AW    = 10,
   parameter int LANES = 8,
   parameter int LW    = 8
) (
   input  wire logic                CLK,
   input  wire logic                we,
   input  wire logic [LANES-1:0]    lane_keep,
   input  wire logic [AW-1:0]       addr,
   input  wire logic [LANES*LW-1:0] wdata,
   output logic      [LANES*LW-1:0] rdata
);
   logic [LANES*LW-1:0] mem [2**AW];

   always_ff @(posedge CLK) begin
      rdata <= mem[addr];
   end

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         // R02 masked lanes kept
         always_ff @(posedge CLK) begin
            if (we && lane_keep[g]) begin
               mem[addr][g*LW +: LW] <= wdata[g*LW +: LW];
            end
         end
      end
   endgenerate
endmodule : sdm_mem
`default_nettype wire

// [rtl/sdm_top.sv]
// SDRAM module command decode, masking, banks, mode, presence-detect pins.
// Assumes a controller driving all pins synchronous to CLK_SYS.
// How it works
// R01: Commands decode only while command_select_n sampled low.
// R02: High byte mask on write discards that lane's data.
// R03: High byte mask on read floats that lane two clocks later.
// R04: Bank select chooses the bank each command acts on.
// R05: Active carries row address, read and write carry column.
// R06: Address bit ten is auto-precharge flag on read and write.
// R07: Precharge scope bit low: one bank; high: all banks.
// R08: Mode load takes mode settings from the address lines.
// R09: Serial clock times every presence-detect transfer; here SPD_CLOCK is only sampled and no transfer is done.
// R10: Serial data line is two-way, in and out; here SPD_DATA_OE is held low, so the line is never driven out.
// R11: All inputs sampled on rising system clock edge.
// R12: Command coded by select, row, column and write strobes.
// R13: Clock gate low suspends internal clock operation.
// R14: Each mask bit governs one eight-bit data lane.
// R15: Data lines direction set by current command.
`timescale 1ns/1ps
`default_nettype none
module sdm_top #(
   parameter int  ROW_W  = sdm_pkg::ROW_W_SMALL,
   parameter int  MEM_AW = 10
) (
   input  wire logic                        CLK_SYS,
   input  wire logic                        RST_N,
   input  wire logic                        CLOCK_GATE,
   input  wire logic                        COMMAND_SELECT_N,
   input  wire logic                        ROW_STROBE_N,
   input  wire logic                        COLUMN_STROBE_N,
   input  wire logic                        WRITE_STROBE_N,
   input  wire logic [sdm_pkg::BANK_W-1:0]  BANK_SELECT,
   input  wire logic [sdm_pkg::ADDR_W-1:0]  ROW_COL_ADDRESS,
   input  wire logic [sdm_pkg::LANES-1:0]   BYTE_LANE_MASK,
   input  wire logic [sdm_pkg::DATA_W-1:0]  DATA_LINES_IN,
   output logic      [sdm_pkg::DATA_W-1:0]  DATA_LINES_OUT,
   output logic      [sdm_pkg::LANES-1:0]   DATA_LINES_OE,
   output logic      [3:0]                  BANK_OPEN,
   output logic      [sdm_pkg::MODE_W-1:0]  MODE_SETTINGS,
   output logic                             AUTO_PRECHARGE,
   input  wire logic                        SPD_CLOCK,
   input  wire logic                        SPD_DATA_IN,
   output logic                             SPD_DATA_OUT,
   output logic                             SPD_DATA_OE
);
   // Elaboration guards on parameters
   if (ROW_W != sdm_pkg::ROW_W_SMALL && ROW_W != sdm_pkg::ROW_W_LARGE) begin : g_bad_row
      $error("ROW_W must be 12 or 13");
   end
   if (MEM_AW < 4 || MEM_AW > 16) begin : g_bad_aw
      $error("MEM_AW out of range");
   end

   localparam int LN = sdm_pkg::LANES;

   // R11 registered pins
   sdm_pkg::sdm_cmd_t  cmd;
   sdm_pkg::sdm_addr_t adr;
   logic [LN-1:0]             mask;
   logic [sdm_pkg::DATA_W-1:0] wdat;
   logic                      cke;

   always_ff @(posedge CLK_SYS) begin
      cmd  <= '{COMMAND_SELECT_N, ROW_STROBE_N, COLUMN_STROBE_N, WRITE_STROBE_N};
      adr  <= '{BANK_SELECT, ROW_COL_ADDRESS};
      mask <= BYTE_LANE_MASK;
      wdat <= DATA_LINES_IN;
      cke  <= CLOCK_GATE;
   end

   // R01 R12 select is part of code
   logic [3:0] code;
   assign code = cke ? cmd : sdm_pkg::CMD_NOP;
   logic is_act, is_rd, is_wr, is_pre, is_mode;
   assign is_act  = code == sdm_pkg::CMD_ACT;
   assign is_rd   = code == sdm_pkg::CMD_RD;
   assign is_wr   = code == sdm_pkg::CMD_WR;
   assign is_pre  = code == sdm_pkg::CMD_PRE;
   assign is_mode = code == sdm_pkg::CMD_MODE;

   // Bank, row, mode state
   logic [3:0]                 bank_open, next_bank_open;
   logic [ROW_W-1:0]           row [4];
   logic [ROW_W-1:0]           next_row [4];
   logic [sdm_pkg::MODE_W-1:0] mode, next_mode;
   logic                       ap, next_ap;
   sdm_pkg::sdm_state_t        state, next_state;
   logic [LN-1:0]              mask_d1, next_mask_d1;
   logic [LN-1:0]              oe, next_oe;
   logic                       rd_pend, next_rd_pend;

   always_comb begin
      next_bank_open = bank_open;
      next_row       = row;
      next_mode      = mode;
      next_ap        = ap;
      next_state     = state;
      next_rd_pend   = is_rd;
      next_mask_d1   = mask;
      next_oe        = oe;
      // R04 R05 row into chosen bank
      if (is_act) begin
         next_bank_open[adr.bank] = 1'b1;
         next_row[adr.bank]       = adr.addr[ROW_W-1:0];
      end
      // R06 auto-precharge flag
      if (is_rd || is_wr) begin
         next_ap = adr.addr[sdm_pkg::AP_BIT];
         if (adr.addr[sdm_pkg::AP_BIT])
            next_bank_open[adr.bank] = 1'b0;
      end
      // R07 precharge scope
      if (is_pre) begin
         if (adr.addr[sdm_pkg::AP_BIT])
            next_bank_open = 4'h0;
         else
            next_bank_open[adr.bank] = 1'b0;
      end
      // R08 mode op-code
      if (is_mode)
         next_mode = adr.addr;
      // R13 clock gate suspend
      case (state)
         sdm_pkg::ST_RUN: begin
            if (!cke)
               next_state = sdm_pkg::ST_SUSPEND;
            else if (is_rd)
               next_state = sdm_pkg::ST_READ;
         end
         sdm_pkg::ST_READ: begin
            if (!cke)
               next_state = sdm_pkg::ST_SUSPEND;
            else if (!is_rd)
               next_state = sdm_pkg::ST_RUN;
         end
         sdm_pkg::ST_SUSPEND: begin
            if (cke)
               next_state = sdm_pkg::ST_RUN;
         end
         default: next_state = sdm_pkg::ST_RUN;
      endcase
      // R03 R14 R15 two-clock mask latency
      if (rd_pend)
         next_oe = ~mask_d1;
      else if (state != sdm_pkg::ST_READ)
         next_oe = '0;
      else
         next_oe = oe & ~mask_d1;
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         bank_open <= 4'h0;
         row       <= '{default: '0};
         mode      <= sdm_pkg::MODE_RST;
         ap        <= 1'b0;
         state     <= sdm_pkg::ST_RUN;
         mask_d1   <= '0;
         oe        <= '0;
         rd_pend   <= 1'b0;
      end else begin
         bank_open <= next_bank_open;
         row       <= next_row;
         mode      <= next_mode;
         ap        <= next_ap;
         state     <= next_state;
         mask_d1   <= next_mask_d1;
         oe        <= next_oe;
         rd_pend   <= next_rd_pend;
      end
   end

   // R02 R04 R05 write into bank and column
   logic [MEM_AW-1:0]          mem_addr;
   logic [sdm_pkg::DATA_W-1:0] mem_rd;
   // R04 Bank bits never cut
   localparam int CW = (MEM_AW - sdm_pkg::BANK_W < sdm_pkg::COL_W) ?
                       MEM_AW - sdm_pkg::BANK_W : sdm_pkg::COL_W;
   logic [sdm_pkg::BANK_W+CW-1:0] bc;
   assign bc       = {adr.bank, adr.addr[CW-1:0]};
   assign mem_addr = MEM_AW'(bc);

   sdm_mem #(
      .AW    (MEM_AW),
      .LANES (LN),
      .LW    (sdm_pkg::LANE_W)
   ) u_mem (
      .CLK       (CLK_SYS),
      .we        (is_wr && bank_open[adr.bank]),
      .lane_keep (~mask),
      .addr      (mem_addr),
      .wdata     (wdat),
      .rdata     (mem_rd)
   );

   // R09 R10 presence-detect pins: sampled, released (no storage here)
   logic spd_clk_q, spd_dat_q;
   always_ff @(posedge CLK_SYS) begin
      spd_clk_q <= SPD_CLOCK;
      spd_dat_q <= SPD_DATA_IN;
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         DATA_LINES_OUT <= '0;
         DATA_LINES_OE  <= '0;
         BANK_OPEN      <= 4'h0;
         MODE_SETTINGS  <= sdm_pkg::MODE_RST;
         AUTO_PRECHARGE <= 1'b0;
         SPD_DATA_OUT   <= 1'b0;
         SPD_DATA_OE    <= 1'b0;
      end else begin
         DATA_LINES_OUT <= mem_rd;
         DATA_LINES_OE  <= next_oe;
         BANK_OPEN      <= bank_open;
         MODE_SETTINGS  <= mode;
         AUTO_PRECHARGE <= ap;
         SPD_DATA_OUT   <= 1'b0;
         SPD_DATA_OE    <= spd_clk_q & spd_dat_q & 1'b0;
      end
   end
endmodule : sdm_top
`default_nettype wire

// [tb/sdm_monitor.sv]
// Checker for the sdm_top ports.
// Assumes outputs follow a sampled command two edges later.
`timescale 1ns/1ps
`default_nettype none
module sdm_chk (
   input wire logic        CLK_SYS,
   input wire logic        RST_N,
   input wire logic        CLOCK_GATE,
   input wire logic        COMMAND_SELECT_N,
   input wire logic        ROW_STROBE_N,
   input wire logic        COLUMN_STROBE_N,
   input wire logic        WRITE_STROBE_N,
   input wire logic [1:0]  BANK_SELECT,
   input wire logic [12:0] ROW_COL_ADDRESS,
   input wire logic [7:0]  BYTE_LANE_MASK,
   input wire logic [7:0]  DATA_LINES_OE,
   input wire logic [3:0]  BANK_OPEN,
   input wire logic [12:0] MODE_SETTINGS,
   input wire logic        AUTO_PRECHARGE
);
   logic       gq;
   logic       ok;
   logic [3:0] c;
   always_ff @(posedge CLK_SYS) gq <= CLOCK_GATE;
   assign ok = CLOCK_GATE & gq;
   assign c  = {COMMAND_SELECT_N, ROW_STROBE_N, COLUMN_STROBE_N, WRITE_STROBE_N} | {4{!ok}};
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   AST_READ_LANES:
      assert property (c == sdm_pkg::CMD_RD |->
         ##3 DATA_LINES_OE == ~$past(BYTE_LANE_MASK, 3)) else $error("read enables");
   AST_DESEL_IDLE:
      assert property (ok && COMMAND_SELECT_N |-> ##3 DATA_LINES_OE == 8'h00)
      else $error("deselect drove");
   AST_MODE_LOAD:
      assert property (c == sdm_pkg::CMD_MODE |->
         ##3 MODE_SETTINGS == $past(ROW_COL_ADDRESS, 3)) else $error("mode value");
   AST_AUTO_PRE:
      assert property (c == sdm_pkg::CMD_RD || c == sdm_pkg::CMD_WR |->
         ##3 AUTO_PRECHARGE == $past(ROW_COL_ADDRESS[10], 3)) else $error("precharge flag");
   AST_ACT_OPEN:
      assert property (c == sdm_pkg::CMD_ACT |-> ##3 BANK_OPEN[$past(BANK_SELECT, 3)])
      else $error("bank not open");
   AST_PRE_ONE:
      assert property (c == sdm_pkg::CMD_PRE && !ROW_COL_ADDRESS[10] |->
         ##3 !BANK_OPEN[$past(BANK_SELECT, 3)]) else $error("bank not closed");
   AST_PRE_ALL:
      assert property (c == sdm_pkg::CMD_PRE && ROW_COL_ADDRESS[10] |-> ##3 BANK_OPEN == 4'h0)
      else $error("banks not closed");
   AST_GATE_HOLD:
      assert property (!CLOCK_GATE |-> ##3 $stable(MODE_SETTINGS))
      else $error("gate ignored");
   AST_RESET_STATE:
      assert property (disable iff (1'b0) !RST_N |=> BANK_OPEN == 4'h0 &&
         MODE_SETTINGS == 13'h0020 && DATA_LINES_OE == 8'h00) else $error("reset state");
   cover property (c == sdm_pkg::CMD_RD && BYTE_LANE_MASK == 8'hff);
   cover property (c == sdm_pkg::CMD_PRE && ROW_COL_ADDRESS[10]);
   cover property (c == sdm_pkg::CMD_MODE);
   cover property (!CLOCK_GATE && !COMMAND_SELECT_N);
endmodule : sdm_chk
bind sdm_top sdm_chk i_chk (.*);
`default_nettype wire

// [tb/sdm_ctl_model.sv]
// Controller model driving command, address, mask and data pins.
// Assumes the bench calls issue; pins change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module sdm_ctl_model (
   input  wire logic          clk,
   output var sdm_pkg::sdm_cmd_t  cmd,
   output var sdm_pkg::sdm_addr_t ba,
   output logic [7:0]         mask,
   output logic [63:0]        wdata,
   output logic               spd_clk,
   output logic               spd_data
);
   assign spd_clk  = 1'b0;
   assign spd_data = 1'b1;
   initial begin
      cmd   = 4'hf;
      ba    = '0;
      mask  = 8'h00;
      wdata = 64'h0;
   end
   task automatic issue(input logic [3:0] c, input logic [14:0] a, input logic [7:0] m,
         input logic [63:0] d);
      @(posedge clk);
      cmd   <= c;
      ba    <= a;
      mask  <= m;
      wdata <= d;
      @(posedge clk);
      cmd   <= 4'hf;
      ba    <= ~a;
      wdata <= ~d;
   endtask : issue
endmodule : sdm_ctl_model
`default_nettype wire

// [tb/tb.sv]
// Bench for sdm_top: random and corner traffic.
// Assumes the controller model drives the pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic               clk_sys, rst_n, gate, spd, sdo, sdoe, spc, sph, ap;
   sdm_pkg::sdm_cmd_t  cmd;
   sdm_pkg::sdm_addr_t ba;
   logic [7:0]         mask, oe;
   logic [63:0]        wd, q, d;
   logic [63:0]        mem [4];
   logic [3:0]         bo;
   logic [12:0]        ms, v;
   int                 failures = 0, num_checks = 0, cyc = 0;
   assign spd = sdoe ? sdo : sph;
   sdm_ctl_model i_ctl (.clk(clk_sys), .cmd(cmd), .ba(ba), .mask(mask), .wdata(wd),
      .spd_clk(spc), .spd_data(sph));
   sdm_top i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CLOCK_GATE(gate),
      .COMMAND_SELECT_N(cmd.select_n), .ROW_STROBE_N(cmd.row_n), .COLUMN_STROBE_N(cmd.col_n),
      .WRITE_STROBE_N(cmd.write_n), .BANK_SELECT(ba.bank), .ROW_COL_ADDRESS(ba.addr),
      .BYTE_LANE_MASK(mask), .DATA_LINES_IN(wd), .DATA_LINES_OUT(q), .DATA_LINES_OE(oe),
      .BANK_OPEN(bo), .MODE_SETTINGS(ms), .AUTO_PRECHARGE(ap), .SPD_CLOCK(spc),
      .SPD_DATA_IN(spd), .SPD_DATA_OUT(sdo), .SPD_DATA_OE(sdoe));
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task final_report;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   function automatic logic [63:0] merge(input logic [63:0] o, v, input logic [7:0] m);
      for (int i = 0; i < 8; i++) if (!m[i]) o[8*i+:8] = v[8*i+:8];
      return o;
   endfunction : merge
   task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
         input logic [7:0] m);
      d = {$urandom, $urandom};
      i_ctl.issue(c, {b, a}, m, d);
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : op
   task automatic wr(input logic [3:0] c, input logic [1:0] b, input logic [7:0] m,
         input logic t);
      op(c, b, {11'h000, b}, m);
      if (t) mem[b] = merge(mem[b], d, m);
   endtask : wr
   task automatic rd(input logic [1:0] b, input logic [7:0] m, input logic a);
      op(sdm_pkg::CMD_RD, b, {2'h0, a, 8'h00, b}, m);
      chk("oe", 8'(~m), oe);
      chk("ap", a, ap);
      for (int i = 0; i < 8; i++) if (!m[i]) chk("lane", mem[b][8*i+:8], q[8*i+:8]);
   endtask : rd
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      rst_n = 1'b0;
      gate  = 1'b1;
      void'($urandom(32'hb760568f));
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      chk("mode", 13'h0020, ms);
      chk("banks", 4'h0, bo);
      @(posedge clk_sys);
      gate <= 1'b0;
      repeat (3) @(posedge clk_sys);
      gate <= 1'b1;
      repeat (2) @(posedge clk_sys);
      for (int k = 0; k < 4; k++) begin
         v = 13'($urandom);
         op(sdm_pkg::CMD_MODE, 2'h0, v, 8'h00);
         chk("mode", v, ms);
      end
      @(posedge clk_sys);
      gate <= 1'b0;
      op(sdm_pkg::CMD_MODE, 2'h0, ~v, 8'h00);
      chk("mode", v, ms);
      @(posedge clk_sys);
      gate <= 1'b1;
      for (int b = 0; b < 4; b++) begin
         op(sdm_pkg::CMD_ACT, 2'(b), 13'($urandom), 8'h00);
         chk("open", 1'b1, bo[b]);
         wr(sdm_pkg::CMD_WR, 2'(b), 8'h00, 1'b1);
         wr(sdm_pkg::CMD_WR, 2'(b), 8'($urandom), 1'b1);
         wr(sdm_pkg::CMD_WR | 4'h8, 2'(b), 8'h00, 1'b0);
         rd(2'(b), b == 0 ? 8'hff : 8'($urandom), 1'b0);
      end
      op(sdm_pkg::CMD_PRE, 2'h1, 13'h0000, 8'h00);
      chk("banks", 4'hd, bo);
      wr(sdm_pkg::CMD_WR, 2'h1, 8'h00, 1'b0);
      op(sdm_pkg::CMD_ACT, 2'h1, 13'h0000, 8'h00);
      rd(2'h1, 8'h00, 1'b0);
      op(sdm_pkg::CMD_PRE, 2'h2, 13'h0400, 8'h00);
      chk("banks", 4'h0, bo);
      op(sdm_pkg::CMD_ACT, 2'h3, 13'h1fff, 8'h00);
      rd(2'h3, 8'h0f, 1'b1);
      chk("spd", 1'b0, sdoe);
      final_report();
   end
endmodule : tb
`default_nettype wire
